// >>> verilog/logic_cell_counter.sv
// logic cell storage register with counter modes and clear/preset schemes
// What this block does
// - up/down mode: count, clock, direction, load enables
// - two three-input functions: count bit, carry
// - two-input selector picks count or load data
// - clear/preset controls load register without lookup
// - clearable mode: sync clear replaces direction
// - selector output ANDed with sync clear
// - emulated bus: contention low, idle high
// - clear and preset active low, unused high
// - async clear from first or second line
// - async load copies third input on first line
// - exactly six asynchronous control schemes
// - chip reset overrides every other control
// - inverted-preset register comes out preset on reset
// - clear-only: the line chosen by clrSecond clears, preset inactive
// - preset by loading one or inverted clear
// - first line loads one, second clears
// - load-with-clear: first loads, second clears
// - load-with-preset: inverted clear presets, data inverted
// - load-only: first line loads third input
// - six dedicated inputs usable as control sources
// - synchronous clock enable, from first input
`timescale 1ns/1ps
module logic_cell_counter #(
  parameter int BUS_N = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [cell_pkg::ADDR_W-1:0] addr,
  input wire logic [cell_pkg::DATA_W-1:0] wdata,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [cell_pkg::DATA_W-1:0] rdata,
  input wire logic cellInputFirst,
  input wire logic cellInputSecond,
  input wire logic cellInputThird,
  input wire logic countEn,
  input wire logic countUp,
  input wire logic loadEn,
  input wire logic syncClearN,
  input wire logic carryIn,
  input wire logic groupControlFirst,
  input wire logic groupControlSecond,
  input wire logic chipResetN,
  input wire logic [cell_pkg::DED_N-1:0] dedIn,
  input wire logic [BUS_N-1:0] busDrvData,
  input wire logic [BUS_N-1:0] busDrvEn,
  output logic regOut,
  output logic carryOut,
  output logic busOut
);
  typedef struct packed {
    logic stored;
    logic shown;
    logic carry;
    logic bus;
    logic [cell_pkg::DATA_W-1:0] rdata;
    cell_pkg::cfg_t cfg;
    cell_pkg::src_t src;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic ctl1;
  logic ctl2;
  logic ce;
  logic inv;
  logic clrN;
  logic prsN;
  logic chipRst;
  logic asyncAct;
  logic dir;
  logic muxOut;
  logic dIn;
  logic cellQ;

  tri_bus_if #(.N(BUS_N)) triBus ();

  // first three-input function: next counter bit
  function automatic logic lutCount(input logic q, input logic cin, input logic en);
    lutCount = q ^ (cin & en);
  endfunction

  // second three-input function: fast carry to the next cell
  function automatic logic lutCarry(input logic q, input logic cin, input logic up);
    lutCarry = up ? (q & cin) : (~q & cin);
  endfunction

  // schemes that keep the stored bit inverted behind the output
  function automatic logic invOf(input cell_pkg::cfg_t c);
    invOf = (c.scheme == cell_pkg::SCH_LOAD_PRS) ||
      (c.scheme == cell_pkg::SCH_PRESET && c.presetInv);
  endfunction

  // pick a control from its pin, a dedicated input or tie high
  function automatic logic pickSrc(input logic [2:0] sel, input logic pin,
                                   input logic [cell_pkg::DED_N-1:0] ded);
    if (sel == cell_pkg::SEL_PIN)
      pickSrc = pin;
    else if (sel == cell_pkg::SEL_ALWAYS)
      pickSrc = 1'b1;
    else
      pickSrc = ded[sel];
  endfunction

  tri_bus_emul #(.N(BUS_N)) busEmul (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .bus(triBus.res)
  );

  // bus drivers come from the user side
  assign triBus.drvData = busDrvData;
  assign triBus.drvEn = busDrvEn;

  // control sources: pins or the dedicated low-skew inputs
  always_comb
  begin
    ctl1 = pickSrc(state_reg.src.ctlSel, groupControlFirst, dedIn);
    ctl2 = groupControlSecond;
    ce = pickSrc(state_reg.src.ceSel, cellInputFirst, dedIn);
  end

  // cell register output through optional inversion
  assign inv = invOf(state_reg.cfg);
  assign cellQ = state_reg.stored ^ inv;
  assign chipRst = state_reg.cfg.chipRstEn && !chipResetN;

  // clear and preset steering, both active low, unused held high
  always_comb
  begin
    clrN = 1'b1;
    prsN = 1'b1;
    unique case (state_reg.cfg.scheme)
      cell_pkg::SCH_CLEAR:
      begin
        clrN = ~(state_reg.cfg.clrSecond ? ctl2 : ctl1);
      end
      cell_pkg::SCH_PRESET:
      begin
        if (state_reg.cfg.presetInv)
          clrN = ~ctl1;
        else
          prsN = ~ctl1;
      end
      cell_pkg::SCH_CLR_PRS:
      begin
        prsN = ~ctl1;
        clrN = ~ctl2;
      end
      cell_pkg::SCH_LOAD_CLR:
      begin
        prsN = ~(ctl1 & cellInputThird);
        clrN = ~((ctl1 & ~cellInputThird) | ctl2);
      end
      cell_pkg::SCH_LOAD_PRS:
      begin
        prsN = ~(ctl1 & ~cellInputThird);
        clrN = ~((ctl1 & cellInputThird) | ctl2);
      end
      cell_pkg::SCH_LOAD:
      begin
        prsN = ~(ctl1 & cellInputThird);
        clrN = ~(ctl1 & ~cellInputThird);
      end
      default:
      begin
        clrN = 1'b1;
        prsN = 1'b1;
      end
    endcase
  end

  assign asyncAct = !clrN || !prsN;

  // counter data path: count function, load selector, sync clear gate
  always_comb
  begin
    dir = (state_reg.cfg.mode == cell_pkg::MODE_CLEARABLE) ? 1'b1 : countUp;
    muxOut = loadEn ? cellInputSecond : lutCount(cellQ, carryIn, countEn);
    dIn = muxOut;
    if (state_reg.cfg.mode == cell_pkg::MODE_CLEARABLE)
      dIn = muxOut & syncClearN;
  end

  // next state: reset, register port, cell register, carry and bus
  always_comb
  begin
    state_next = state_reg;
    state_next.carry = lutCarry(cellQ, carryIn, dir);
    state_next.bus = triBus.busValue;
    state_next.rdata = '0;
    if (wrStb && addr == cell_pkg::CFG_IDX)
      state_next.cfg = cell_pkg::cfg_t'(wdata[cell_pkg::CFG_W-1:0]);
    if (wrStb && addr == cell_pkg::SRC_IDX)
      state_next.src = cell_pkg::src_t'(wdata[cell_pkg::SRC_W-1:0]);
    if (rdStb)
    begin
      unique case (addr)
        cell_pkg::CFG_IDX: state_next.rdata = {1'b0, state_reg.cfg};
        cell_pkg::STAT_IDX: state_next.rdata = {5'h00, state_reg.bus, state_reg.carry, cellQ};
        cell_pkg::SRC_IDX: state_next.rdata = {2'h0, state_reg.src};
        default: state_next.rdata = '0;
      endcase
    end
    if (chipRst)
      state_next.stored = 1'b0;
    else if (!clrN)
      state_next.stored = 1'b0;
    else if (!prsN)
      state_next.stored = 1'b1;
    else if (ce)
      state_next.stored = dIn ^ inv;
    if (!nrst)
    begin
      state_next = '0;
      state_next.cfg = cell_pkg::CFG_RST;
      state_next.src = cell_pkg::SRC_RST;
    end
    // output copy of the cell bit, so the pin comes straight from a flop
    state_next.shown = state_next.stored ^ invOf(state_next.cfg);
  end

  // the single state register
  always_ff @(posedge clk_sys)
  begin
    state_reg <= state_next;
  end

  // outputs straight from the state register
  assign rdata = state_reg.rdata;
  assign regOut = state_reg.shown;
  assign carryOut = state_reg.carry;
  assign busOut = state_reg.bus;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // a clocked update with no control or config write in the way
  sequence syncStep;
    !chipRst && clrN && prsN && ce && !wrStb;
  endsequence

  // an async control, then a free cycle that loads synchronously
  sequence asyncThenFree;
    asyncAct ##1 (!asyncAct && !chipRst && ce && !wrStb && loadEn &&
      state_reg.cfg.mode == cell_pkg::MODE_UPDOWN);
  endsequence

  AST_SYNC_LOAD: assert property (
    syncStep and (state_reg.cfg.mode == cell_pkg::MODE_UPDOWN && loadEn)
    |=> regOut == $past(cellInputSecond))
    else $error("sync load missed");
  AST_SYNC_CLEAR: assert property (
    syncStep and (state_reg.cfg.mode == cell_pkg::MODE_CLEARABLE && !syncClearN)
    |=> !regOut)
    else $error("sync clear missed");
  AST_COUNT_TOGGLE: assert property (
    syncStep and (!loadEn && countEn && carryIn && syncClearN)
    |=> regOut != $past(regOut))
    else $error("count did not toggle");
  AST_CE_HOLD: assert property (
    (!chipRst && clrN && prsN && !ce && !wrStb) |=> $stable(regOut))
    else $error("register moved without enable");
  AST_CHIP_RESET: assert property (
    (chipRst && !wrStb) |=> regOut == $past(inv))
    else $error("chip reset not dominant");
  AST_CLEAR_ONLY: assert property (
    (!chipRst && !wrStb && state_reg.cfg.scheme == cell_pkg::SCH_CLEAR && !clrN)
    |=> !regOut)
    else $error("clear scheme did not clear");
  AST_ASYNC_LOAD: assert property (
    (!chipRst && !wrStb && state_reg.cfg.scheme == cell_pkg::SCH_LOAD && ctl1)
    |=> regOut == $past(cellInputThird))
    else $error("async load wrong value");
  AST_CLR_PRS: assert property (
    (!chipRst && !wrStb && state_reg.cfg.scheme == cell_pkg::SCH_CLR_PRS && ctl1 && !ctl2)
    |=> regOut)
    else $error("preset by load of one failed");
  AST_LOAD_PRS: assert property (
    (!chipRst && !wrStb && state_reg.cfg.scheme == cell_pkg::SCH_LOAD_PRS && ctl2)
    |=> regOut)
    else $error("inverted clear did not preset");
  AST_RESUME: assert property (
    asyncThenFree |=> regOut == $past(cellInputSecond))
    else $error("no clocked resume after release");
  AST_LOAD_CLR: assert property (
    (!chipRst && !wrStb && state_reg.cfg.scheme == cell_pkg::SCH_LOAD_CLR && ctl1 && !ctl2)
    |=> regOut == $past(cellInputThird))
    else $error("load with clear wrong value");
  AST_PRESET_ONLY: assert property (
    (!chipRst && !wrStb && state_reg.cfg.scheme == cell_pkg::SCH_PRESET && ctl1)
    |=> regOut)
    else $error("preset scheme did not preset");
  AST_SCHEME_IDLE: assert property (
    (!chipRst && !wrStb && !ce && (ctl1 || ctl2) && state_reg.cfg.scheme > cell_pkg::SCH_LOAD)
    |=> $stable(regOut))
    else $error("unused scheme code moved register");
  AST_CARRY_UP: assert property (
    (state_reg.cfg.mode == cell_pkg::MODE_UPDOWN && countUp && carryIn && regOut)
    |=> carryOut)
    else $error("up count carry missing");
endmodule

// >>> pkg/cell_pkg.sv
// shared types and constants for the logic cell register and counter
package cell_pkg;
  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CFG_IDX = 2'h0;
  localparam logic [ADDR_W-1:0] STAT_IDX = 2'h1;
  localparam logic [ADDR_W-1:0] SRC_IDX = 2'h2;
  // dedicated low-skew inputs and source selector codes
  localparam int DED_N = 6;
  localparam logic [2:0] SEL_ALWAYS = 3'h6;
  localparam logic [2:0] SEL_PIN = 3'h7;
  // clear and preset schemes; codes 6 and 7 are illegal
  typedef enum logic [2:0] {
    SCH_CLEAR = 3'h0,
    SCH_PRESET = 3'h1,
    SCH_CLR_PRS = 3'h2,
    SCH_LOAD_CLR = 3'h3,
    SCH_LOAD_PRS = 3'h4,
    SCH_LOAD = 3'h5
  } scheme_t;
  // counter operating modes
  typedef enum logic {
    MODE_UPDOWN = 1'b0,
    MODE_CLEARABLE = 1'b1
  } cmode_t;
  // configuration word, low bits of the config register
  typedef struct packed {
    logic presetInv;
    logic chipRstEn;
    logic clrSecond;
    scheme_t scheme;
    cmode_t mode;
  } cfg_t;
  localparam int CFG_W = 7;
  localparam cfg_t CFG_RST = '{1'b0, 1'b1, 1'b0, SCH_CLEAR, MODE_UPDOWN};
  // control source word, low bits of the source register
  typedef struct packed {
    logic [2:0] ctlSel;
    logic [2:0] ceSel;
  } src_t;
  localparam int SRC_W = 6;
  localparam src_t SRC_RST = '{SEL_PIN, SEL_PIN};
endpackage

// >>> pkg/tri_bus_if.sv
// carrier between the cell top and the tri-state bus emulator
`timescale 1ns/1ps
interface tri_bus_if #(parameter int N = 4);
  logic [N-1:0] drvData;
  logic [N-1:0] drvEn;
  logic busValue;
  modport src (output drvData, output drvEn, input busValue);
  modport res (input drvData, input drvEn, output busValue);
endinterface

// >>> verilog/tri_bus_emul.sv
// multiplexer that stands in for an internal tri-state bus
`timescale 1ns/1ps
module tri_bus_emul #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  tri_bus_if.res bus
);
  // count enabled drivers: none floats high, contention resolves low
  always_comb
  begin
    bus.busValue = 1'b1;
    if ($countones(bus.drvEn) > 1)
    begin
      bus.busValue = 1'b0;
    end
    else if (bus.drvEn != '0)
    begin
      bus.busValue = |(bus.drvData & bus.drvEn);
    end
  end

  AST_BUS_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (bus.drvEn == '0) |-> bus.busValue)
    else $error("idle bus not high");
  AST_BUS_FIGHT: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($countones(bus.drvEn) > 1) |-> !bus.busValue)
    else $error("contending bus not low");
endmodule

// >>> tb/user_logic_model.sv
// surrounding user logic: group control drivers and emulated bus drivers
`timescale 1ns/1ps
module user_logic_model (
  input wire logic clk_sys,
  input wire logic reqFirst,
  input wire logic reqSecond,
  input wire logic [3:0] enMask,
  input wire logic [3:0] dataVal,
  output logic groupControlFirst,
  output logic groupControlSecond,
  output logic [3:0] busDrvEn,
  output logic [3:0] busDrvData
);
  logic junk = 1'b0;
  // idle drivers show a level that flips every cycle, never a held value
  always_ff @(posedge clk_sys)
    junk <= ~junk;
  // control lines stay deasserted unless a request is made
  assign groupControlFirst = reqFirst;
  assign groupControlSecond = reqSecond;
  // enabled drivers carry their data, idle ones carry noise
  assign busDrvEn = enMask;
  assign busDrvData = (dataVal & enMask) | ({4{junk}} & ~enMask);
endmodule

// >>> tb/logic_cell_counter_tb.sv
// self-checking bench for the logic cell register and counter
`timescale 1ns/1ps
`define CHECK(g, e) begin checkCount++; if ((g) !== (e)) begin numErrors++; $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module logic_cell_counter_tb;
  logic clk_sys, nrst, wrStb, rdStb, first, second, third, countEn, countUp, loadEn;
  logic syncClearN, carryIn, chipResetN, reqFirst, reqSecond, regOut, carryOut, busOut;
  logic gcFirst, gcSecond;
  logic [cell_pkg::ADDR_W-1:0] addr;
  logic [cell_pkg::DATA_W-1:0] wdata, rdata, rd;
  logic [cell_pkg::DED_N-1:0] dedIn;
  logic [3:0] enMask, dataVal, drvEn, drvData;
  int numErrors = 0;
  int checkCount = 0;

  logic_cell_counter dut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .cellInputFirst(first),
    .cellInputSecond(second), .cellInputThird(third), .countEn(countEn),
    .countUp(countUp), .loadEn(loadEn), .syncClearN(syncClearN), .carryIn(carryIn),
    .groupControlFirst(gcFirst), .groupControlSecond(gcSecond), .chipResetN(chipResetN),
    .dedIn(dedIn), .busDrvData(drvData), .busDrvEn(drvEn), .regOut(regOut),
    .carryOut(carryOut), .busOut(busOut));
  user_logic_model partner (.clk_sys(clk_sys), .reqFirst(reqFirst), .reqSecond(reqSecond),
    .enMask(enMask), .dataVal(dataVal), .groupControlFirst(gcFirst),
    .groupControlSecond(gcSecond), .busDrvEn(drvEn), .busDrvData(drvData));

  // 10 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk_sys);
    wrStb <= 1'b0;
  endtask

  task automatic rdReg(input logic [1:0] a);
    @(posedge clk_sys);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk_sys);
    rdStb <= 1'b0;
    #1;
    rd = rdata;
  endtask

  task automatic setCfg(input cell_pkg::scheme_t s, input logic m, input logic cs,
                        input logic pinv);
    wr(cell_pkg::CFG_IDX, {1'b0, pinv, 1'b1, cs, s, m});
  endtask

  // preload by synchronous load, then apply group controls and chip reset
  task automatic ctl(input logic pre, f, s, t, cr, exp);
    @(posedge clk_sys);
    first <= 1'b1;
    loadEn <= 1'b1;
    second <= pre;
    tick();
    `CHECK(regOut, pre)
    @(posedge clk_sys);
    first <= 1'b0;
    loadEn <= 1'b0;
    reqFirst <= f;
    reqSecond <= s;
    third <= t;
    chipResetN <= cr;
    tick();
    `CHECK(regOut, exp)
    // release the controls and load the opposite value in the very next cycle
    @(posedge clk_sys);
    reqFirst <= 1'b0;
    reqSecond <= 1'b0;
    chipResetN <= 1'b1;
    first <= 1'b1;
    loadEn <= 1'b1;
    second <= ~exp;
    tick();
    `CHECK(regOut, ~exp)
  endtask

  task automatic regScenario();
    rdReg(cell_pkg::CFG_IDX);
    `CHECK(rd, 8'h20)
    rdReg(cell_pkg::SRC_IDX);
    `CHECK(rd, 8'h3f)
    wr(2'h3, 8'h5a);
    rdReg(2'h3);
    `CHECK(rd, 8'h00)
  endtask

  task automatic loadScenario();
    @(posedge clk_sys);
    first <= 1'b1;
    loadEn <= 1'b1;
    second <= 1'b1;
    tick();
    `CHECK(regOut, 1'b1)
    @(posedge clk_sys);
    first <= 1'b0;
    second <= 1'b0;
    tick();
    `CHECK(regOut, 1'b1)
    rdReg(cell_pkg::STAT_IDX);
    `CHECK(rd[0], 1'b1)
    wr(cell_pkg::SRC_IDX, 8'h38);
    @(posedge clk_sys);
    dedIn <= 6'h01;
    tick();
    `CHECK(regOut, 1'b0)
    wr(cell_pkg::SRC_IDX, 8'h3f);
  endtask

  task automatic countScenario();
    @(posedge clk_sys);
    first <= 1'b1;
    loadEn <= 1'b0;
    dedIn <= 6'h00;
    countEn <= 1'b1;
    carryIn <= 1'b1;
    countUp <= 1'b1;
    tick();
    `CHECK(regOut, 1'b1)
    tick();
    `CHECK(regOut, 1'b0)
    `CHECK(carryOut, 1'b1)
    @(posedge clk_sys);
    carryIn <= 1'b0;
    tick();
    tick();
    `CHECK(regOut, 1'b1)
    @(posedge clk_sys);
    carryIn <= 1'b1;
    countUp <= 1'b0;
    tick();
    `CHECK(regOut, 1'b0)
    @(posedge clk_sys);
    countEn <= 1'b0;
  endtask

  task automatic clearableScenario();
    setCfg(cell_pkg::SCH_CLEAR, 1'b1, 1'b0, 1'b0);
    @(posedge clk_sys);
    loadEn <= 1'b1;
    second <= 1'b1;
    syncClearN <= 1'b0;
    tick();
    `CHECK(regOut, 1'b0)
    @(posedge clk_sys);
    syncClearN <= 1'b1;
    tick();
    `CHECK(regOut, 1'b1)
  endtask

  task automatic schemeScenario();
    setCfg(cell_pkg::SCH_CLEAR, 1'b0, 1'b0, 1'b0);
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    setCfg(cell_pkg::SCH_CLEAR, 1'b0, 1'b1, 1'b0);
    ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    setCfg(cell_pkg::SCH_PRESET, 1'b0, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    setCfg(cell_pkg::SCH_PRESET, 1'b0, 1'b0, 1'b1);
    ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    setCfg(cell_pkg::scheme_t'(3'h6), 1'b0, 1'b0, 1'b0);
    ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    setCfg(cell_pkg::SCH_CLR_PRS, 1'b0, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    setCfg(cell_pkg::SCH_LOAD_CLR, 1'b0, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    setCfg(cell_pkg::SCH_LOAD_PRS, 1'b0, 1'b0, 1'b0);
    ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    setCfg(cell_pkg::SCH_LOAD, 1'b0, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    ctl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    // first control line from dedicated input 1, clock always enabled
    wr(cell_pkg::SRC_IDX, 8'h0e);
    @(posedge clk_sys);
    dedIn <= 6'h02;
    third <= 1'b0;
    tick();
    `CHECK(regOut, 1'b0)
    @(posedge clk_sys);
    dedIn <= 6'h00;
    tick();
    `CHECK(regOut, 1'b1)
  endtask

  task automatic busCase(input logic [3:0] en, d, input logic exp);
    @(posedge clk_sys);
    enMask <= en;
    dataVal <= d;
    tick();
    `CHECK(busOut, exp)
  endtask

  task automatic giveVerdict();
    if (numErrors == 0 && checkCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog well beyond the roughly 150 cycles the sequence needs
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    numErrors++;
    giveVerdict();
  end

  // main sequence
  initial
  begin
    {nrst, wrStb, rdStb, first, second, third, countEn, countUp, loadEn} = '0;
    {carryIn, reqFirst, reqSecond, addr, wdata, dedIn, enMask, dataVal} = '0;
    syncClearN = 1'b1;
    chipResetN = 1'b1;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    regScenario();
    loadScenario();
    countScenario();
    clearableScenario();
    schemeScenario();
    busCase(4'h0, 4'h0, 1'b1);
    busCase(4'h6, 4'hf, 1'b0);
    busCase(4'h4, 4'h4, 1'b1);
    busCase(4'h4, 4'h0, 1'b0);
    giveVerdict();
  end
endmodule
